// *** design/bfs_pkg.sv ***
// Package: constants, states and carrier structs for the breaker sequencer
package bfs_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned FAST_QUAL_NS = 500;
  localparam int unsigned SLOW_QUAL_US = 18;
  localparam int unsigned LOGIC_RST_US = 10;
  localparam int unsigned BRK_RST_US = 120;
  // Least times round up
  localparam int unsigned FAST_QUAL_CYC =
    (FAST_QUAL_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SLOW_QUAL_CYC = SLOW_QUAL_US * (CLK_HZ / 1000000);
  localparam int unsigned LOGIC_RST_CYC = LOGIC_RST_US * (CLK_HZ / 1000000);
  localparam int unsigned BRK_RST_CYC = BRK_RST_US * (CLK_HZ / 1000000);
  localparam int unsigned CW = 13;

  // AXI register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATE = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_CLR = 4'hC;
  localparam logic [3:0] REG_IRQ_EN = 4'h0;
  localparam logic [3:0] REG_IRQ_EN_ADDR = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_SLOW = 0;
  localparam int unsigned EV_FAST = 1;
  localparam int unsigned EV_EXT = 2;
  localparam int unsigned EV_BRST = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int unsigned CTRL_EXT_TRIP = 0;
  localparam int unsigned CTRL_IRQ_EN_LSB = 4;

  typedef enum {
    BFS_IDLE, BFS_CYCLE1, BFS_WAIT2, BFS_CYCLE2, BFS_RUN
  } bfs_state_t;

  typedef struct packed {
    logic [2:0] en_sync;
    logic [2:0] flt_sync;
    logic [2:0] fast_sync;
    logic [2:0] slow_sync;
  } bfs_sync_t;

  typedef struct packed {
    logic soft_start;
    logic pull_up;
    logic gate_gnd;
    logic gate_gentle;
    logic fault_n_oe;
    logic pgt_oe_n;
    logic pgf_oe_n;
    logic pg_reset;
  } bfs_drive_t;
endpackage

// *** design/bfs_top.sv ***
// Breaker fault sequencer: detectors, trip latch, enable-low reset, AXI regs
//
// How it works
// - Cycle two start: soft-start drive, arm fast.
// - Cycle two end: pull-up drive, arm slow.
// - Slow detector trips after qualified low-band overcurrent.
// - Fast detector trips after qualified high overcurrent.
// - Trip grounds pass-switch drive immediately.
// - Trip latches fault low, resets power-good.
// - Tripped: short timer and filter pins.
// - After clear, enable high restarts power-up.
// - Enable low short interval resets logic, gentle pull-down.
// - Breaker stays tripped until reset interval passes.
// - Enable low long enough clears breaker, fault.
// - Enable rising starts first timing cycle.
// - Cycle two starts only if fault line high.
`timescale 1ns/10ps
module bfs_top
  import bfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable_hi,
  input wire logic enable_lo_n,
  input wire logic fault_line_hi,
  input wire logic fast_over,
  input wire logic slow_over,
  input wire logic timer_done,
  input wire logic pg_trip,
  output logic gate_soft_start,
  output logic gate_pull_up,
  output logic gate_to_gnd,
  output logic gate_gentle_down,
  output logic fault_n_o,
  output logic fault_n_oe,
  output logic power_good_timer_pin_oe,
  output logic glitch_filter_pin_oe,
  output logic pg_reset,
  output logic timer_run,
  output logic irq,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    bfs_sync_t sy;
    bfs_state_t st;
    logic tripped;
    logic en_prev;
    logic [CW-1:0] fast_cnt;
    logic [CW-1:0] slow_cnt;
    logic [CW-1:0] low_cnt;
    logic fast_armed;
    logic slow_armed;
    logic logic_rst;
    bfs_drive_t dr;
    logic timer_run;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] irq_en;
    logic ext_trip;
    logic irq;
    logic [3:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bfs_regs_t;

  bfs_regs_t r;
  bfs_regs_t next_r;

  // Second and third stages agree before a change counts
  function automatic logic agreed(input logic [2:0] s, input logic old);
    agreed = (s[1] == s[2]) ? s[2] : old;
  endfunction

  logic en_q;
  logic en_low_q;
  logic flt_q;
  logic fast_q;
  logic slow_q;
  logic trip_now;
  logic [EV_W-1:0] ev;
  logic [31:0] rd;

  always_comb
  begin
    next_r = r;
    // Three-stage sampling of asynchronous comparators
    next_r.sy.en_sync = {r.sy.en_sync[1:0], enable_hi & enable_lo_n};
    next_r.sy.flt_sync = {r.sy.flt_sync[1:0], fault_line_hi};
    next_r.sy.fast_sync = {r.sy.fast_sync[1:0], fast_over};
    next_r.sy.slow_sync = {r.sy.slow_sync[1:0], slow_over};
    en_q = agreed(r.sy.en_sync, r.en_prev);
    en_low_q = ~en_q;
    flt_q = (r.sy.flt_sync[1] == r.sy.flt_sync[2]) & r.sy.flt_sync[2];
    fast_q = (r.sy.fast_sync[1] == r.sy.fast_sync[2]) & r.sy.fast_sync[2];
    slow_q = (r.sy.slow_sync[1] == r.sy.slow_sync[2]) & r.sy.slow_sync[2];
    next_r.en_prev = en_q;
    ev = '0;

    // Fast qualification counter
    if (r.fast_armed && fast_q && !r.tripped)
      next_r.fast_cnt = r.fast_cnt + 1'b1;
    else
      next_r.fast_cnt = '0;
    // Slow qualification counter, low band only
    if (r.slow_armed && slow_q && !fast_q && !r.tripped)
      next_r.slow_cnt = r.slow_cnt + 1'b1;
    else
      next_r.slow_cnt = '0;

    ev[EV_FAST] = (r.fast_cnt == CW'(FAST_QUAL_CYC - 1)) && next_r.fast_cnt != 0;
    ev[EV_SLOW] = (r.slow_cnt == CW'(SLOW_QUAL_CYC)) && next_r.slow_cnt != 0;
    ev[EV_EXT] = !r.tripped && (pg_trip || r.ext_trip) && r.st == BFS_RUN;
    trip_now = ev[EV_FAST] | ev[EV_SLOW] | ev[EV_EXT];

    // Enable-low interval counter
    if (en_low_q)
    begin
      if (r.low_cnt != CW'(BRK_RST_CYC))
        next_r.low_cnt = r.low_cnt + 1'b1;
    end
    else
      next_r.low_cnt = '0;
    next_r.logic_rst = en_low_q && (r.low_cnt >= CW'(LOGIC_RST_CYC - 1));

    // Trip latch; cleared only after the long interval
    if (trip_now)
      next_r.tripped = 1'b1;
    else if (r.tripped && en_low_q && r.low_cnt == CW'(BRK_RST_CYC - 1))
    begin
      next_r.tripped = 1'b0;
      ev[EV_BRST] = 1'b1;
    end

    // Sequence
    case (r.st)
      BFS_IDLE:
        if (!r.tripped && en_q && !r.en_prev)
          next_r.st = BFS_CYCLE1;
      BFS_CYCLE1:
        if (timer_done)
          next_r.st = BFS_WAIT2;
      BFS_WAIT2:
        if (flt_q)
          next_r.st = BFS_CYCLE2;
      BFS_CYCLE2:
        if (timer_done)
          next_r.st = BFS_RUN;
      BFS_RUN:
        next_r.st = BFS_RUN;
      default:
        next_r.st = BFS_IDLE;
    endcase
    if (trip_now || r.tripped || next_r.logic_rst)
      next_r.st = BFS_IDLE;

    next_r.fast_armed = (next_r.st == BFS_CYCLE2 || next_r.st == BFS_RUN);
    next_r.slow_armed = (next_r.st == BFS_RUN);
    next_r.timer_run = (next_r.st == BFS_CYCLE1 || next_r.st == BFS_CYCLE2);

    // Pin drive
    next_r.dr.soft_start = (next_r.st == BFS_CYCLE2);
    next_r.dr.pull_up = (next_r.st == BFS_RUN);
    next_r.dr.gate_gnd = next_r.tripped;
    // Gentle pull-down joins even when already grounded by a trip
    next_r.dr.gate_gentle = next_r.logic_rst;
    next_r.dr.fault_n_oe = !next_r.tripped;
    next_r.dr.pgt_oe_n = !(next_r.tripped || next_r.st != BFS_RUN);
    next_r.dr.pgf_oe_n = !next_r.tripped;
    next_r.dr.pg_reset = next_r.tripped || next_r.st != BFS_RUN;

    // AXI4-Lite slave
    if (s_axi_awvalid && !r.aw_have)
    begin
      next_r.aw_have = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_have)
    begin
      next_r.w_have = 1'b1;
      next_r.wdata = s_axi_wdata;
    end
    next_r.ext_trip = 1'b0;
    if (r.aw_have && r.w_have && !r.bvalid)
    begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.awaddr)
        REG_CTRL:
        begin
          next_r.ext_trip = r.wdata[CTRL_EXT_TRIP];
          next_r.irq_en = r.wdata[CTRL_IRQ_EN_LSB +: EV_W];
        end
        REG_IRQ_CLR:
          next_r.status = r.status & ~r.wdata[EV_W-1:0];
        REG_STATE, REG_IRQ_STAT:
          next_r.bresp = RESP_OKAY;
        default:
          next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    // Set wins over clear
    next_r.status = next_r.status | ev;
    next_r.irq = |(next_r.status & next_r.irq_en);

    rd = 32'h0;
    case (s_axi_araddr)
      REG_CTRL: rd = {24'h0, r.irq_en, 4'h0};
      REG_STATE: rd = {24'h0, 3'h0, r.st == BFS_RUN, r.slow_armed,
                       r.fast_armed, r.logic_rst, r.tripped};
      REG_IRQ_STAT: rd = {28'h0, r.status};
      default: rd = 32'h0;
    endcase
    if (s_axi_arvalid && !r.rvalid)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd;
      next_r.rresp = (s_axi_araddr >= REG_IRQ_CLR) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st <= BFS_IDLE;
      r.dr.fault_n_oe <= 1'b1;
      r.dr.pgt_oe_n <= 1'b0;
      r.dr.pgf_oe_n <= 1'b1;
      r.dr.pg_reset <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign gate_soft_start = r.dr.soft_start;
  assign gate_pull_up = r.dr.pull_up;
  assign gate_to_gnd = r.dr.gate_gnd;
  assign gate_gentle_down = r.dr.gate_gentle;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = r.dr.fault_n_oe;
  assign power_good_timer_pin_oe = r.dr.pgt_oe_n;
  assign glitch_filter_pin_oe = r.dr.pgf_oe_n;
  assign pg_reset = r.dr.pg_reset;
  assign timer_run = r.timer_run;
  assign irq = r.irq;
  assign s_axi_awready = !r.aw_have;
  assign s_axi_wready = !r.w_have;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  sequence s_fast_run;
    (r.fast_armed && fast_q && !r.tripped) [*5];
  endsequence
  // Twenty sampled cycles over the high threshold trip on the next edge
  property p_fast_trip;
    @(posedge aclk) disable iff (!aresetn)
      s_fast_run ##1 s_fast_run ##1 s_fast_run ##1 s_fast_run |=> r.tripped;
  endproperty
  a_fast_trip: assert property (p_fast_trip) else $error("fast no trip");
  property p_gentle;
    @(posedge aclk) disable iff (!aresetn)
      r.logic_rst |-> gate_gentle_down && r.st == BFS_IDLE;
  endproperty
  a_gentle: assert property (p_gentle) else $error("no pull");
  property p_slow_trip;
    @(posedge aclk) disable iff (!aresetn)
      (r.slow_cnt == CW'(SLOW_QUAL_CYC) && slow_q && !fast_q && r.slow_armed)
      |=> r.tripped;
  endproperty
  a_slow_trip: assert property (p_slow_trip) else $error("slow no trip");
  property p_gate_gnd;
    @(posedge aclk) disable iff (!aresetn)
      $rose(r.tripped) |-> r.dr.gate_gnd && !r.dr.pull_up && !r.dr.soft_start;
  endproperty
  a_gate_gnd: assert property (p_gate_gnd) else $error("gate not grounded");
  property p_fault_low;
    @(posedge aclk) disable iff (!aresetn)
      r.tripped |-> !fault_n_oe && pg_reset;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault not low");
  property p_pins_short;
    @(posedge aclk) disable iff (!aresetn)
      r.tripped |-> !power_good_timer_pin_oe && !glitch_filter_pin_oe;
  endproperty
  a_pins_short: assert property (p_pins_short) else $error("pins open");
  property p_hold_trip;
    @(posedge aclk) disable iff (!aresetn)
      r.tripped && r.low_cnt < CW'(BRK_RST_CYC - 1) |=> r.tripped;
  endproperty
  a_hold_trip: assert property (p_hold_trip) else $error("early clear");
  property p_soft;
    @(posedge aclk) disable iff (!aresetn)
      r.st == BFS_CYCLE2 |-> r.fast_armed && r.dr.soft_start && !r.slow_armed;
  endproperty
  a_soft: assert property (p_soft) else $error("cycle two drive");
  property p_run;
    @(posedge aclk) disable iff (!aresetn)
      r.st == BFS_RUN |-> r.slow_armed && r.dr.pull_up && !r.dr.soft_start;
  endproperty
  a_run: assert property (p_run) else $error("run drive");
  property p_gate14;
    @(posedge aclk) disable iff (!aresetn)
      r.st == BFS_WAIT2 && !flt_q |=> r.st != BFS_CYCLE2;
  endproperty
  a_gate14: assert property (p_gate14) else $error("fault low start");
endmodule

// *** verif/bfs_far_side.sv ***
// Backplane side model: enable divider and pulled-up fault line
`timescale 1ns/10ps
module bfs_far_side
(
  input wire logic en_cmd,
  input wire logic hold_fault_low,
  input wire logic fault_n_oe,
  output logic enable_hi,
  output logic enable_lo_n,
  output logic fault_line_hi
);
  // Clean edges: both enable comparators flip together
  assign enable_hi = en_cmd;
  assign enable_lo_n = en_cmd;
  // Pull-up wins unless device or board pulls low
  assign fault_line_hi = fault_n_oe & ~hold_fault_low;
endmodule

// *** verif/bfs_top_tb.sv ***
// Self-checking bench for the breaker fault sequencer
`timescale 1ns/10ps
module bfs_top_tb;
  import bfs_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic en_cmd = 1'h0;
  logic hold_fault_low = 1'h0;
  logic timer_done = 1'h0;
  logic fast_over = 1'h0;
  logic slow_over = 1'h0;
  logic pg_trip = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic enable_hi, enable_lo_n, fault_line_hi, fault_n_o, fault_n_oe;
  logic gate_soft_start, gate_pull_up, gate_to_gnd, gate_gentle_down;
  logic power_good_timer_pin_oe, glitch_filter_pin_oe;
  logic pg_reset, timer_run, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int mismatches = 0;
  int n_tests = 0;

  bfs_far_side i_far (.en_cmd, .hold_fault_low, .fault_n_oe, .enable_hi,
    .enable_lo_n, .fault_line_hi);
  bfs_top i_dut (.aclk, .aresetn, .enable_hi, .enable_lo_n, .fault_line_hi,
    .fast_over, .slow_over, .timer_done, .pg_trip, .gate_soft_start,
    .gate_pull_up, .gate_to_gnd, .gate_gentle_down, .fault_n_o, .fault_n_oe,
    .power_good_timer_pin_oe, .glitch_filter_pin_oe, .pg_reset, .timer_run,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t pin %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t word %h want %h", $time, got, exp);
    end
  endtask

  // Sample at falling edges so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(negedge aclk);
  endtask

  // Bus flag by index: 0 bvalid, 1 arready, 2 rvalid
  function automatic logic bus_flag(input int which);
    case (which)
      0: return s_axi_bvalid;
      1: return s_axi_arready;
      default: return s_axi_rvalid;
    endcase
  endfunction

  // Ends on the falling edge where the flag is high
  task automatic wait_hi(input int which);
    int k;
    @(negedge aclk);
    for (k = 0; k < 100 && bus_flag(which) !== 1'h1; k++)
      @(negedge aclk);
    if (bus_flag(which) !== 1'h1)
    begin
      mismatches++;
      $display("[FAIL] %0t bus stuck", $time);
      give_verdict();
    end
  endtask

  // Slave may take address and data in either order
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    int k;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (k = 0; k < 100 && (pa || pw); k++)
    begin
      @(negedge aclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    if (pa || pw)
    begin
      mismatches++;
      $display("[FAIL] %0t write not taken", $time);
      give_verdict();
    end
    s_axi_bready <= 1'h1;
    wait_hi(0);
    chk_v({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    wait_hi(1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    wait_hi(2);
    chk_v({30'h0, s_axi_rresp}, {30'h0, er});
    if (er === RESP_OKAY)
      chk_v(s_axi_rdata, ed);
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  task automatic tick();
    @(posedge aclk) timer_done <= 1'h1;
    @(posedge aclk) timer_done <= 1'h0;
  endtask

  task automatic power_up();
    @(posedge aclk) en_cmd <= 1'h1;
    wt(8);
    chk(timer_run, 1'h1);
    tick();
    wt(8);
    chk(gate_soft_start, 1'h1);
    tick();
    wt(4);
    chk(gate_pull_up, 1'h1);
    chk(gate_soft_start, 1'h0);
    chk(pg_reset, 1'h0);
    rd(REG_STATE, 32'h1C, RESP_OKAY);
    $display("power_up end");
  endtask

  task automatic fast_trip();
    wr(REG_CTRL, 32'hF0);
    @(posedge aclk) fast_over <= 1'h1;
    wt(FAST_QUAL_CYC - 5);
    chk(gate_to_gnd, 1'h0);
    wt(15);
    chk(gate_to_gnd, 1'h1);
    chk(gate_pull_up, 1'h0);
    chk(fault_n_oe, 1'h0);
    chk(pg_reset, 1'h1);
    chk(power_good_timer_pin_oe, 1'h0);
    chk(glitch_filter_pin_oe, 1'h0);
    chk(irq, 1'h1);
    chk(fault_n_o, 1'h0);
    rd(REG_STATE, 32'h1, RESP_OKAY);
    @(posedge aclk) fast_over <= 1'h0;
    $display("fast_trip end");
  endtask

  // Interrupt masked during the trip, then unmasked
  task automatic slow_trip();
    wr(REG_CTRL, 32'h0);
    @(posedge aclk) slow_over <= 1'h1;
    wt(SLOW_QUAL_CYC - 10);
    chk(gate_to_gnd, 1'h0);
    wt(40);
    chk(gate_to_gnd, 1'h1);
    chk(fault_n_oe, 1'h0);
    chk(irq, 1'h0);
    wr(REG_CTRL, 32'hF0);
    wt(2);
    chk(irq, 1'h1);
    @(posedge aclk) slow_over <= 1'h0;
    $display("slow_trip end");
  endtask

  task automatic retry(input logic [31:0] stat);
    @(posedge aclk) en_cmd <= 1'h0;
    wt(LOGIC_RST_CYC + 20);
    chk(gate_gentle_down, 1'h1);
    wt(BRK_RST_CYC - LOGIC_RST_CYC - 120);
    chk(fault_n_oe, 1'h0);
    wt(140);
    chk(fault_n_oe, 1'h1);
    rd(REG_IRQ_STAT, stat, RESP_OKAY);
    wr(REG_IRQ_CLR, 32'hF);
    rd(REG_IRQ_STAT, 32'h0, RESP_OKAY);
    wt(2);
    chk(irq, 1'h0);
    $display("retry end");
  endtask

  task automatic fault_held();
    @(posedge aclk) hold_fault_low <= 1'h1;
    @(posedge aclk) en_cmd <= 1'h1;
    wt(8);
    chk(timer_run, 1'h1);
    tick();
    wt(10);
    chk(gate_soft_start, 1'h0);
    @(posedge aclk) hold_fault_low <= 1'h0;
    wt(8);
    chk(gate_soft_start, 1'h1);
    $display("fault_held end");
  endtask

  // Power-good trip pin, or the software trip bit, while running
  task automatic ext_trip(input logic by_pin);
    if (by_pin)
    begin
      @(posedge aclk) pg_trip <= 1'h1;
      @(posedge aclk) pg_trip <= 1'h0;
    end
    else
      wr(REG_CTRL, 32'hF1);
    wt(3);
    chk(gate_to_gnd, 1'h1);
    chk(gate_pull_up, 1'h0);
    chk(fault_n_oe, 1'h0);
    chk(glitch_filter_pin_oe, 1'h0);
    $display("ext_trip end");
  endtask

  initial
  begin
    wt(20);
    @(posedge aclk) aresetn <= 1'h1;
    rd(REG_IRQ_CLR, 32'h0, RESP_SLVERR);
    power_up();
    fast_trip();
    retry(32'hA);
    power_up();
    slow_trip();
    retry(32'h9);
    fault_held();
    tick();
    wt(2);
    ext_trip(1'h1);
    retry(32'hC);
    power_up();
    ext_trip(1'h0);
    retry(32'hC);
    give_verdict();
  end
endmodule
